// File: hw/ctt_pkg.sv
// package: register map, fields and types of the counter/timer block
package ctt_pkg;
    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [3:0] IDX_AUX_CTRL = 4'h4;
    localparam logic [3:0] IDX_INT_STATUS = 4'h5;
    localparam logic [3:0] IDX_INT_MASK = 4'h5;
    localparam logic [3:0] IDX_COUNT_UPPER = 4'h6;
    localparam logic [3:0] IDX_PRELOAD_UPPER = 4'h6;
    localparam logic [3:0] IDX_COUNT_LOWER = 4'h7;
    localparam logic [3:0] IDX_PRELOAD_LOWER = 4'h7;
    localparam logic [3:0] IDX_RX_CTRL = 4'h8;
    localparam logic [3:0] IDX_OUT_CONFIG = 4'hD;
    localparam logic [3:0] IDX_START_CMD = 4'hE;
    localparam logic [3:0] IDX_STOP_CMD = 4'hF;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CT_READY_BIT = 3;
    localparam int RXRDY_A_BIT = 1;
    localparam int RXRDY_B_BIT = 5;
    localparam int CLK_SEL_LO = 4;
    localparam int TIMER_MODE_BIT = 6;
    localparam int OUT_SEL_LO = 2;
    localparam int OUT_SEL_CT = 1;
    localparam int WD_EN_A_BIT = 0;
    localparam int WD_EN_B_BIT = 1;
    localparam int TMO_A_BIT = 2;
    localparam int TMO_B_BIT = 3;
    // ------------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------------
    localparam logic [15:0] PRELOAD_RESET = 16'h0001;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int WD_BIT_TIMES = 64;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] addr;
        logic        valid;
    } ctt_addr_s;
    typedef struct packed {
        logic [6:0] wd_cnt;
        logic       wd_run;
    } ctt_wdog_s;
endpackage

// File: hw/ctt_top.sv
// counter/timer with receive timeout and per-receiver watchdogs
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// - preload 0x0001..0xFFFF, rewritable any time
// - counter mode after reset
// - counter start read loads preload, counts
// - counter 1 to 0 sets ready bit 3
// - counter ready pulls interrupt low only when mask bit 3 set
// - counter wraps to 0xFFFF, keeps counting
// - counter ignores new preload until start or receive reload
// - counter stop read halts, clears ready
// - received character reloads counter from preload
// - no character before zero sets ready
// - timer stop read only clears ready
// - timer square wave, period twice preload
// - timer start read: output high, reload
// - timer tick at count one: toggle output, reload, repeat
// - timer ready set on output rising edge
// - timer takes new preload at reload
// - clock select 6:4, pin route 3:2
// - per-receiver watchdog, 64 bit times
// - watchdog timeout raises receiver-ready
module ctt_top (
    // clock and reset
    input wire logic CLOCK_IN,
    input wire logic RESET_IN,
    // axi4-lite write address and data
    input wire logic [31:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    // axi4-lite write response
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    // axi4-lite read
    input wire logic [31:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    // counter clock sources, pins
    input wire logic [7:0] CT_CLK_SRC_IN,
    // receiver events, same clock domain
    input wire logic [1:0] RX_CHAR_IN,
    input wire logic [1:0] RX_BIT_TICK_IN,
    // outputs
    output logic INT_N_OUT,
    output logic TIMER_OUTPUT_PIN_OUT,
    output logic TIMER_BAUD_CLK_OUT,
    output logic [1:0] RX_TIMEOUT_OUT
);
    typedef struct packed {
        logic [7:0] src_s1;
        logic [7:0] src_s2;
        logic       src_prev;
        logic [15:0] preload;
        logic [15:0] count;
        logic       running;
        logic       reload;
        logic       ct_out;
        logic       ct_ready;
        logic       wd_flag_a;
        logic       wd_flag_b;
        logic [7:0] int_mask;
        logic [7:0] aux_ctrl;
        logic [7:0] out_config;
        logic [7:0] rx_ctrl;
        ctt_pkg::ctt_wdog_s wd_a;
        ctt_pkg::ctt_wdog_s wd_b;
        ctt_pkg::ctt_addr_s aw;
        logic       w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ctt_state_s;

    ctt_state_s st;
    ctt_state_s nx;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // word index of a byte address, null when unaligned or out of range
    function automatic logic [4:0] ctt_index(input logic [31:0] a);
        if (a[1:0] != 2'h0 || a[31:6] != 26'h0) begin
            return 5'h10;
        end
        return {1'b0, a[5:2]};
    endfunction

    // one watchdog step: restart on character, count bit ticks, fire once
    function automatic ctt_pkg::ctt_wdog_s ctt_wd_step(
        input ctt_pkg::ctt_wdog_s w, input logic en, input logic chr,
        input logic tick, output logic fire);
        ctt_pkg::ctt_wdog_s r;
        r = w;
        fire = 1'b0;
        if (!en) begin
            r.wd_run = 1'b0;
            r.wd_cnt = 7'h00;
        end else if (chr) begin
            r.wd_run = 1'b1;
            r.wd_cnt = 7'h00;
        end else if (w.wd_run && tick) begin
            if (w.wd_cnt == 7'(ctt_pkg::WD_BIT_TIMES - 1)) begin
                fire = 1'b1;
                r.wd_run = 1'b0;
                r.wd_cnt = 7'h00;
            end else begin
                r.wd_cnt = w.wd_cnt + 7'h01;
            end
        end
        return r;
    endfunction

    logic timer_mode;
    logic src_sel;
    logic ct_tick;
    logic [4:0] ar_idx;
    logic [4:0] aw_idx;
    logic do_read;
    logic do_write;
    logic start_cmd;
    logic stop_cmd;
    logic rx_reload;
    logic wd_fire_a;
    logic wd_fire_b;
    logic [7:0] isr_view;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        nx = st;
        timer_mode = st.aux_ctrl[ctt_pkg::TIMER_MODE_BIT];
        // clock source select and edge detect on synchronised pins
        src_sel = st.src_s2[st.aux_ctrl[ctt_pkg::CLK_SEL_LO +: 3]];
        ct_tick = src_sel && !st.src_prev;
        nx.src_s1 = CT_CLK_SRC_IN;
        nx.src_s2 = st.src_s1;
        nx.src_prev = src_sel;
        isr_view = 8'h00;
        isr_view[ctt_pkg::CT_READY_BIT] = st.ct_ready;
        isr_view[ctt_pkg::RXRDY_A_BIT] = st.wd_flag_a;
        isr_view[ctt_pkg::RXRDY_B_BIT] = st.wd_flag_b;
        // read channel
        ar_idx = ctt_index(S_AXI_ARADDR_IN);
        do_read = S_AXI_ARVALID_IN && !st.rvalid;
        start_cmd = do_read && ar_idx == {1'b0, ctt_pkg::IDX_START_CMD};
        stop_cmd = do_read && ar_idx == {1'b0, ctt_pkg::IDX_STOP_CMD};
        if (st.rvalid && S_AXI_RREADY_IN) begin
            nx.rvalid = 1'b0;
        end
        if (do_read) begin
            nx.rvalid = 1'b1;
            nx.rresp = ctt_pkg::AXI_OKAY;
            nx.rdata = 32'h0000_0000;
            case (ar_idx)
                {1'b0, ctt_pkg::IDX_INT_STATUS}:
                    nx.rdata[7:0] = isr_view;
                {1'b0, ctt_pkg::IDX_COUNT_UPPER}:
                    nx.rdata[7:0] = st.count[15:8];
                {1'b0, ctt_pkg::IDX_COUNT_LOWER}:
                    nx.rdata[7:0] = st.count[7:0];
                {1'b0, ctt_pkg::IDX_RX_CTRL}:
                    nx.rdata[7:0] = st.rx_ctrl;
                {1'b0, ctt_pkg::IDX_START_CMD},
                {1'b0, ctt_pkg::IDX_STOP_CMD}:
                    nx.rdata[7:0] = 8'h00;
                default:
                    nx.rresp = ctt_pkg::AXI_SLVERR;
            endcase
        end
        // write channel: take address and data in either order
        if (S_AXI_AWVALID_IN && !st.aw.valid && !st.bvalid) begin
            nx.aw.valid = 1'b1;
            nx.aw.addr = S_AXI_AWADDR_IN;
        end
        if (S_AXI_WVALID_IN && !st.w_have && !st.bvalid) begin
            nx.w_have = 1'b1;
            nx.wdata = S_AXI_WDATA_IN;
            nx.wstrb = S_AXI_WSTRB_IN;
        end
        if (st.bvalid && S_AXI_BREADY_IN) begin
            nx.bvalid = 1'b0;
        end
        aw_idx = ctt_index(st.aw.addr);
        do_write = st.aw.valid && st.w_have && !st.bvalid;
        if (do_write) begin
            nx.aw.valid = 1'b0;
            nx.w_have = 1'b0;
            nx.bvalid = 1'b1;
            nx.bresp = ctt_pkg::AXI_OKAY;
            if (st.wstrb[0]) begin
                case (aw_idx)
                    {1'b0, ctt_pkg::IDX_AUX_CTRL}:
                        nx.aux_ctrl = st.wdata[7:0];
                    {1'b0, ctt_pkg::IDX_INT_MASK}:
                        nx.int_mask = st.wdata[7:0];
                    {1'b0, ctt_pkg::IDX_PRELOAD_UPPER}:
                        nx.preload[15:8] = st.wdata[7:0];
                    {1'b0, ctt_pkg::IDX_PRELOAD_LOWER}:
                        nx.preload[7:0] = st.wdata[7:0];
                    {1'b0, ctt_pkg::IDX_RX_CTRL}:
                        nx.rx_ctrl = st.wdata[7:0];
                    {1'b0, ctt_pkg::IDX_OUT_CONFIG}:
                        nx.out_config = st.wdata[7:0];
                    default:
                        nx.bresp = ctt_pkg::AXI_SLVERR;
                endcase
            end
        end
        // counter/timer core
        // start, receive reload and the timer reload at count one copy the preload into the count
        rx_reload = (RX_CHAR_IN[0] && st.rx_ctrl[ctt_pkg::TMO_A_BIT]) ||
            (RX_CHAR_IN[1] && st.rx_ctrl[ctt_pkg::TMO_B_BIT]);
        if (stop_cmd) begin
            nx.ct_ready = 1'b0;
            if (!timer_mode) begin
                nx.running = 1'b0;
            end
        end
        if (start_cmd) begin
            nx.count = st.preload;
            nx.running = 1'b1;
            nx.reload = 1'b0;
            if (timer_mode) begin
                nx.ct_out = 1'b1;
            end
        end else if (rx_reload && !timer_mode) begin
            nx.count = st.preload;
            nx.running = 1'b1;
            nx.reload = 1'b0;
        end else if (st.running && ct_tick) begin
            if (timer_mode) begin
                if (st.count == 16'h0001) begin
                    nx.count = st.preload;
                    nx.ct_out = !st.ct_out;
                    if (!st.ct_out) begin
                        nx.ct_ready = 1'b1;
                    end
                end else begin
                    nx.count = st.count - 16'h0001;
                end
            end else begin
                nx.count = st.count - 16'h0001;
                if (st.count == 16'h0001) begin
                    nx.ct_ready = 1'b1;
                end
            end
        end
        // receiver watchdogs
        nx.wd_a = ctt_wd_step(st.wd_a, st.rx_ctrl[ctt_pkg::WD_EN_A_BIT],
            RX_CHAR_IN[0], RX_BIT_TICK_IN[0], wd_fire_a);
        nx.wd_b = ctt_wd_step(st.wd_b, st.rx_ctrl[ctt_pkg::WD_EN_B_BIT],
            RX_CHAR_IN[1], RX_BIT_TICK_IN[1], wd_fire_b);
        if (do_read && ar_idx == {1'b0, ctt_pkg::IDX_INT_STATUS}) begin
            nx.wd_flag_a = 1'b0;
            nx.wd_flag_b = 1'b0;
        end
        if (wd_fire_a) begin
            nx.wd_flag_a = 1'b1;
        end
        if (wd_fire_b) begin
            nx.wd_flag_b = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            st <= '0;
            st.preload <= ctt_pkg::PRELOAD_RESET;
            st.count <= ctt_pkg::COUNT_ALL_ONES;
            st.aux_ctrl <= ctt_pkg::REG_RESET;
        end else begin
            st <= nx;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign S_AXI_AWREADY_OUT = !st.aw.valid && !st.bvalid;
    assign S_AXI_WREADY_OUT = !st.w_have && !st.bvalid;
    assign S_AXI_BVALID_OUT = st.bvalid;
    assign S_AXI_BRESP_OUT = st.bresp;
    assign S_AXI_ARREADY_OUT = !st.rvalid;
    assign S_AXI_RVALID_OUT = st.rvalid;
    assign S_AXI_RDATA_OUT = st.rdata;
    assign S_AXI_RRESP_OUT = st.rresp;
    // active-low interrupt from masked status
    assign INT_N_OUT = !((isr_view & st.int_mask) != 8'h00);
    // square wave offered to both channels
    assign TIMER_BAUD_CLK_OUT = st.ct_out;
    // pin shows timer output when routed
    assign TIMER_OUTPUT_PIN_OUT =
        (st.out_config[ctt_pkg::OUT_SEL_LO +: 2] == 2'(ctt_pkg::OUT_SEL_CT))
        ? st.ct_out : 1'b0;
    assign RX_TIMEOUT_OUT = {st.wd_flag_b, st.wd_flag_a};

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_counter_tc_ready: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN)
        (!timer_mode && st.running && ct_tick && st.count == 16'h0001 &&
         !start_cmd && !rx_reload) |=> st.ct_ready && st.count == 16'h0000)
        else $error("counter terminal count missed");
    a_counter_wrap: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN)
        (!timer_mode && st.running && ct_tick && st.count == 16'h0000 &&
         !start_cmd && !rx_reload && !stop_cmd) |=> st.count == 16'hFFFF)
        else $error("counter did not wrap");
    a_start_loads: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN)
        start_cmd |=> st.running && st.count == $past(st.preload))
        else $error("start did not load preload");
    a_stop_halts: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN)
        (stop_cmd && !timer_mode && !start_cmd) |=> !st.running ##1
        (st.running || $stable(st.count)))
        else $error("stop did not halt");
    a_timer_no_stop: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN)
        (stop_cmd && timer_mode && st.running) |=> st.running && !st.ct_ready)
        else $error("timer stopped by stop read");
    a_timer_start_high: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN)
        (start_cmd && timer_mode) |=> st.ct_out)
        else $error("timer output not high on start");
    a_timer_toggle: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN)
        (timer_mode && st.running && ct_tick && st.count == 16'h0001 &&
         !start_cmd) |=> st.ct_out != $past(st.ct_out) &&
        st.count == $past(st.preload))
        else $error("timer did not toggle and reload");
    a_timer_ready_rise: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN)
        (timer_mode && $rose(st.ct_ready)) |-> $rose(st.ct_out))
        else $error("timer ready not on rising output");
    a_int_masked: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN)
        (st.ct_ready && st.int_mask[ctt_pkg::CT_READY_BIT]) |-> !INT_N_OUT)
        else $error("interrupt not asserted");
    a_rx_reload: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN)
        (rx_reload && !start_cmd && !timer_mode) |=>
        st.count == $past(st.preload))
        else $error("receive reload missed");
    a_wd_fire_flag: assert property (@(posedge CLOCK_IN)
        disable iff (RESET_IN)
        wd_fire_a |=> st.wd_flag_a && !st.wd_a.wd_run)
        else $error("watchdog timeout not flagged");
endmodule

// File: verif/ctt_top_test.sv
// self-checking testbench of the counter/timer block
`timescale 1ns/1ps
module ctt_top_test;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rx_tmo, last_bresp;
    logic [7:0] src = 8'h00;
    logic [1:0] rx_char = 2'h0, bit_tick = 2'h0;
    logic int_n, pin, baud;
    logic [15:0] lfsr = 16'h0009;
    int n_mismatch = 0;
    int samples_checked = 0;

    // clock at 5 ns period
    always #2.5 clk = ~clk;

    ctt_top u_dut (
        .CLOCK_IN(clk), .RESET_IN(rst),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
        .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
        .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
        .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
        .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
        .S_AXI_RREADY_IN(rready), .CT_CLK_SRC_IN(src),
        .RX_CHAR_IN(rx_char), .RX_BIT_TICK_IN(bit_tick),
        .INT_N_OUT(int_n), .TIMER_OUTPUT_PIN_OUT(pin),
        .TIMER_BAUD_CLK_OUT(baud), .RX_TIMEOUT_OUT(rx_tmo)
    );

    // ------------------------------------------------------------------
    // expectation helpers and compares
    // ------------------------------------------------------------------
    // count after t ticks from preload p, wrapping below zero
    function automatic logic [15:0] exp_count(input logic [15:0] p,
                                              input logic [15:0] t);
        return p - t;
    endfunction

    // pseudo-random step
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // bus word compare: response code and data together
    task automatic check_word(input logic [33:0] got, input logic [33:0] e);
        samples_checked++;
        if (got !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask

    // pin compare: 0 irq, 1 baud, 2 pin, 3 timeout a, 4 timeout b
    task automatic check_pin(input int which, input logic e);
        logic [4:0] pv;
        @(negedge clk);
        pv = {rx_tmo, pin, baud, int_n};
        samples_checked++;
        if (pv[which] !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, pv[which], e);
        end
        @(posedge clk);
    endtask

    // ------------------------------------------------------------------
    // bus master and stimulus tasks, all entered just after a rising edge
    // ------------------------------------------------------------------
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= {26'h0, idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(negedge clk);
            aw_ok = aw_ok || (awvalid && awready === 1'b1);
            w_ok = w_ok || (wvalid && wready === 1'b1);
            @(posedge clk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        bready <= 1'b1;
        do @(negedge clk); while (bvalid !== 1'b1);
        last_bresp = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] idx, output logic [33:0] got);
        araddr <= {26'h0, idx, 2'h0};
        arvalid <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(negedge clk); while (rvalid !== 1'b1);
        got = {rresp, rdata};
        @(posedge clk);
        rready <= 1'b0;
    endtask

    task automatic check_rd(input logic [3:0] idx, input logic [7:0] e);
        logic [33:0] got;
        rd(idx, got);
        check_word(got, {ctt_pkg::AXI_OKAY, 24'h0, e});
    endtask

    task automatic check_count(input logic [15:0] e);
        check_rd(ctt_pkg::IDX_COUNT_UPPER, e[15:8]);
        check_rd(ctt_pkg::IDX_COUNT_LOWER, e[7:0]);
    endtask

    task automatic set_preload(input logic [15:0] p);
        wr(ctt_pkg::IDX_PRELOAD_UPPER, p[15:8]);
        wr(ctt_pkg::IDX_PRELOAD_LOWER, p[7:0]);
    endtask

    // n rising edges on counter clock source s, slow against the bus clock
    task automatic tick(input logic [2:0] s, input int n);
        repeat (n) begin
            src <= 8'h01 << s;
            repeat (4) @(posedge clk);
            src <= 8'h00;
            repeat (4) @(posedge clk);
        end
    endtask

    task automatic pulse_char(input logic [1:0] m);
        rx_char <= m;
        @(posedge clk);
        rx_char <= 2'h0;
        @(posedge clk);
    endtask

    task automatic bit_ticks(input logic [1:0] m, input int n);
        repeat (n) begin
            bit_tick <= m;
            @(posedge clk);
            bit_tick <= 2'h0;
            @(posedge clk);
        end
    endtask

    // ------------------------------------------------------------------
    // watchdog against hangs
    // ------------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [33:0] got;
        logic [15:0] n;
        logic [2:0] s;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check_pin(0, 1'b1);
        check_rd(ctt_pkg::IDX_INT_STATUS, 8'h00);
        rd(4'h0, got);
        check_word(got, {ctt_pkg::AXI_SLVERR, 32'h0});
        wr(4'h0, 8'h00);
        check_word({last_bresp, 32'h0}, {ctt_pkg::AXI_SLVERR, 32'h0});
        // counter mode, first pass relies on the reset mode and source
        for (int it = 0; it < 3; it++) begin
            lfsr = lfsr_next(lfsr);
            n = {13'h0, lfsr[2:0]} + 16'h0002;
            s = (it == 0) ? 3'h0 : {1'b0, lfsr[5:4]};
            if (it > 0) wr(ctt_pkg::IDX_AUX_CTRL, {1'b0, s, 4'h0});
            wr(ctt_pkg::IDX_INT_MASK, 8'h08);
            set_preload(n);
            check_word({last_bresp, 32'h0}, {ctt_pkg::AXI_OKAY, 32'h0});
            rd(ctt_pkg::IDX_START_CMD, got);
            check_count(n);
            tick(s ^ 3'h1, 2);
            check_count(n);
            tick(s, n - 1);
            check_rd(ctt_pkg::IDX_INT_STATUS, 8'h00);
            check_pin(0, 1'b1);
            set_preload(n + 16'h0001);
            tick(s, 1);
            check_rd(ctt_pkg::IDX_INT_STATUS, 8'h08);
            check_pin(0, 1'b0);
            tick(s, 2);
            check_count(exp_count(n, n + 16'h0002));
            rd(ctt_pkg::IDX_STOP_CMD, got);
            check_rd(ctt_pkg::IDX_INT_STATUS, 8'h00);
            check_pin(0, 1'b1);
            tick(s, 2);
            check_count(exp_count(n, n + 16'h0002));
            rd(ctt_pkg::IDX_START_CMD, got);
            check_count(n + 16'h0001);
            wr(ctt_pkg::IDX_INT_MASK, 8'h00);
            tick(s, n + 1);
            check_rd(ctt_pkg::IDX_INT_STATUS, 8'h08);
            check_pin(0, 1'b1);
            rd(ctt_pkg::IDX_STOP_CMD, got);
        end
        // receive timeout on channel a only
        wr(ctt_pkg::IDX_RX_CTRL, 8'h04);
        // preload is n + 1 after the loop: n ticks leave the count at one
        pulse_char(2'h1);
        tick(s, n);
        pulse_char(2'h1);
        tick(s, n);
        check_rd(ctt_pkg::IDX_INT_STATUS, 8'h00);
        tick(s, 1);
        check_rd(ctt_pkg::IDX_INT_STATUS, 8'h08);
        rd(ctt_pkg::IDX_STOP_CMD, got);
        // per-receiver watchdogs
        wr(ctt_pkg::IDX_RX_CTRL, 8'h03);
        for (int c = 0; c < 2; c++) begin
            pulse_char(2'h1 << c);
            bit_ticks(2'h3, 63);
            check_pin(3 + c, 1'b0);
            bit_ticks(2'h1 << c, 1);
            check_pin(3 + c, 1'b1);
            check_rd(ctt_pkg::IDX_INT_STATUS, (c == 0) ? 8'h02 : 8'h20);
            bit_ticks(2'h3, 70);
            check_pin(3 + c, 1'b0);
        end
        // timer mode on sources 4 to 7
        lfsr = lfsr_next(lfsr);
        n = {14'h0, lfsr[1:0]} + 16'h0002;
        s = {1'b1, lfsr[3:2]};
        wr(ctt_pkg::IDX_AUX_CTRL, {1'b0, s, 4'h0});
        set_preload(n);
        wr(ctt_pkg::IDX_OUT_CONFIG, 8'h00);
        rd(ctt_pkg::IDX_START_CMD, got);
        check_pin(1, 1'b1);
        check_pin(2, 1'b0);
        wr(ctt_pkg::IDX_OUT_CONFIG, 8'h04);
        tick(s, n - 1);
        check_pin(2, 1'b1);
        tick(s, 1);
        check_pin(1, 1'b0);
        check_rd(ctt_pkg::IDX_INT_STATUS, 8'h00);
        set_preload(n + 16'h0001);
        tick(s, n);
        check_pin(1, 1'b1);
        check_rd(ctt_pkg::IDX_INT_STATUS, 8'h08);
        rd(ctt_pkg::IDX_STOP_CMD, got);
        check_rd(ctt_pkg::IDX_INT_STATUS, 8'h00);
        tick(s, n);
        check_pin(1, 1'b1);
        tick(s, 1);
        check_pin(1, 1'b0);
        rd(ctt_pkg::IDX_START_CMD, got);
        check_pin(1, 1'b1);
        report_and_stop();
    end
endmodule
